// >>> design/mid_decoder.sv
// opcode decoder with machine-cycle counter for an 8-bit core
// assumes: fetch bytes arrive one per clock with a valid strobe
//
// What this block does
// - lengths 1-3 bytes, times 1/2/4; mul/div four
// - a machine cycle is two clock periods
// - eight-code blocks take register from bits 2:0
// - absolute jump/call by low five bits, page high
// - add forms decoded, each one cycle
// - add-with-carry forms decoded, each one cycle
// - subtract-with-borrow forms, each one cycle
// - and forms; immediate-to-direct two cycles
// - or forms; immediate-to-direct two cycles
// - xor forms; immediate-to-direct two cycles
// - one-cycle accumulator clear, complement, swap, rotates
// - acc/register moves one cycle; direct-to-reg two
// - data pointer load and code fetches two cycles
// - external data access one byte two cycles
// - push/pop two cycles; exchanges one cycle
// - carry and/or with bit two cycles
// - bit to carry one, carry to bit two
// - long call, return, interrupt return two cycles
// - long, short, indirect jumps two cycles
// - conditional relative branches two cycles
// - compare/decrement branches three bytes two cycles
// - 00 no-op; A5 store or break by select
`timescale 1ns/1ns
`include "mid_map.svh"
module mid_decoder import mid_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // extension select field
    input wire logic [3:0] extended_opcode_select,
    // fetch stream
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    output logic fetch_ready,
    // datapath control
    output mid_dec_t dec_out,
    output logic [7:0] opnd1,
    output logic [7:0] opnd2,
    output logic busy,
    output logic mc_tick,
    output logic insn_done
);
    logic rst_s1_r;
    logic rst_s2_r;
    mid_state_t s_r;
    mid_state_t s_nxt;
    logic [7:0] opnd1_r;
    logic [7:0] opnd2_r;

    function automatic mid_dec_t mk(mid_op_t op, mid_src_t src,
                                    logic [1:0] len, logic [2:0] cyc);
        mid_dec_t d;
        d = '0;
        d.op = op;
        d.src = src;
        d.len = len;
        d.cyc = cyc;
        return d;
    endfunction

    function automatic mid_dec_t decode(logic [7:0] o, logic [3:0] sel);
        mid_dec_t d;
        logic [3:0] hi;
        hi = o[7:4];
        d = mk(MID_OP_RSV, MID_SRC_NONE, 2'd1, 3'd1);
        if (o[3]) begin
            // eight-code register blocks
            unique case (hi)
                4'h0: d = mk(MID_OP_INC, MID_SRC_REG, 2'd1, 3'd1);
                4'h1: d = mk(MID_OP_DEC, MID_SRC_REG, 2'd1, 3'd1);
                4'h2: d = mk(MID_OP_ADD, MID_SRC_REG, 2'd1, 3'd1);
                4'h3: d = mk(MID_OP_ADDC, MID_SRC_REG, 2'd1, 3'd1);
                4'h4: d = mk(MID_OP_ORL, MID_SRC_REG, 2'd1, 3'd1);
                4'h5: d = mk(MID_OP_ANL, MID_SRC_REG, 2'd1, 3'd1);
                4'h6: d = mk(MID_OP_XRL, MID_SRC_REG, 2'd1, 3'd1);
                4'h7: d = mk(MID_OP_MOV, MID_SRC_IMM, 2'd2, 3'd1);
                4'h8: d = mk(MID_OP_MOV, MID_SRC_REG, 2'd2, 3'd2);
                4'h9: d = mk(MID_OP_SUBB, MID_SRC_REG, 2'd1, 3'd1);
                4'hA: d = mk(MID_OP_MOV, MID_SRC_DIR, 2'd2, 3'd2);
                4'hB: d = mk(MID_OP_CJNE, MID_SRC_IMM, 2'd3, 3'd2);
                4'hC: d = mk(MID_OP_XCH, MID_SRC_REG, 2'd1, 3'd1);
                4'hD: d = mk(MID_OP_DJNZ, MID_SRC_REG, 2'd3, 3'd2);
                4'hE: d = mk(MID_OP_MOV, MID_SRC_REG, 2'd1, 3'd1);
                4'hF: d = mk(MID_OP_MOV, MID_SRC_ACC, 2'd1, 3'd1);
            endcase
            d.wreg = o[`MID_REG_LSB +: `MID_REG_W];
            d.use_wreg = 1'b1;
        end else if (o[4:0] == `MID_AJ_JMP_LOW || o[4:0] == `MID_AJ_CALL_LOW)
        begin
            // absolute forms carry the page
            d = mk(o[4] ? MID_OP_ACALL : MID_OP_AJMP, MID_SRC_NONE,
                   2'd2, 3'd2);
            d.page = o[7:5];
        end else if (o[2:1] == 2'b11) begin
            // indirect pointer register pairs
            unique case (hi)
                4'h0: d = mk(MID_OP_INC, MID_SRC_IND, 2'd1, 3'd1);
                4'h1: d = mk(MID_OP_DEC, MID_SRC_IND, 2'd1, 3'd1);
                4'h2: d = mk(MID_OP_ADD, MID_SRC_IND, 2'd1, 3'd1);
                4'h3: d = mk(MID_OP_ADDC, MID_SRC_IND, 2'd1, 3'd1);
                4'h4: d = mk(MID_OP_ORL, MID_SRC_IND, 2'd1, 3'd1);
                4'h5: d = mk(MID_OP_ANL, MID_SRC_IND, 2'd1, 3'd1);
                4'h6: d = mk(MID_OP_XRL, MID_SRC_IND, 2'd1, 3'd1);
                4'h7: d = mk(MID_OP_MOV, MID_SRC_IMM, 2'd2, 3'd1);
                4'h8: d = mk(MID_OP_MOV, MID_SRC_IND, 2'd2, 3'd2);
                4'h9: d = mk(MID_OP_SUBB, MID_SRC_IND, 2'd1, 3'd1);
                4'hA: d = mk(MID_OP_MOV, MID_SRC_DIR, 2'd2, 3'd2);
                4'hB: d = mk(MID_OP_CJNE, MID_SRC_IND, 2'd3, 3'd2);
                4'hC: d = mk(MID_OP_XCH, MID_SRC_IND, 2'd1, 3'd1);
                4'hD: d = mk(MID_OP_XCHD, MID_SRC_IND, 2'd1, 3'd1);
                4'hE: d = mk(MID_OP_MOV, MID_SRC_IND, 2'd1, 3'd1);
                4'hF: d = mk(MID_OP_MOV, MID_SRC_ACC, 2'd1, 3'd1);
            endcase
            d.wreg = {2'b00, o[0]};
            d.use_wreg = 1'b1;
        end else begin
            unique case (o)
                8'h00: d = mk(MID_OP_NOP, MID_SRC_NONE, 2'd1, 3'd1);
                8'h02: d = mk(MID_OP_LJMP, MID_SRC_NONE, 2'd3, 3'd2);
                8'h03: d = mk(MID_OP_RR, MID_SRC_ACC, 2'd1, 3'd1);
                8'h04: d = mk(MID_OP_INC, MID_SRC_ACC, 2'd1, 3'd1);
                8'h05: d = mk(MID_OP_INC, MID_SRC_DIR, 2'd2, 3'd1);
                8'h10: d = mk(MID_OP_JBC, MID_SRC_DIR, 2'd3, 3'd2);
                8'h12: d = mk(MID_OP_LCALL, MID_SRC_NONE, 2'd3, 3'd2);
                8'h13: d = mk(MID_OP_RRC, MID_SRC_ACC, 2'd1, 3'd1);
                8'h14: d = mk(MID_OP_DEC, MID_SRC_ACC, 2'd1, 3'd1);
                8'h15: d = mk(MID_OP_DEC, MID_SRC_DIR, 2'd2, 3'd1);
                8'h20: d = mk(MID_OP_JB, MID_SRC_DIR, 2'd3, 3'd2);
                8'h22: d = mk(MID_OP_RET, MID_SRC_NONE, 2'd1, 3'd2);
                8'h23: d = mk(MID_OP_RL, MID_SRC_ACC, 2'd1, 3'd1);
                8'h24: d = mk(MID_OP_ADD, MID_SRC_IMM, 2'd2, 3'd1);
                8'h25: d = mk(MID_OP_ADD, MID_SRC_DIR, 2'd2, 3'd1);
                8'h30: d = mk(MID_OP_JNB, MID_SRC_DIR, 2'd3, 3'd2);
                8'h32: d = mk(MID_OP_RETI, MID_SRC_NONE, 2'd1, 3'd2);
                8'h33: d = mk(MID_OP_RLC, MID_SRC_ACC, 2'd1, 3'd1);
                8'h34: d = mk(MID_OP_ADDC, MID_SRC_IMM, 2'd2, 3'd1);
                8'h35: d = mk(MID_OP_ADDC, MID_SRC_DIR, 2'd2, 3'd1);
                8'h40: d = mk(MID_OP_JC, MID_SRC_CARRY, 2'd2, 3'd2);
                8'h42: d = mk(MID_OP_ORL, MID_SRC_ACC, 2'd2, 3'd1);
                8'h43: d = mk(MID_OP_ORL, MID_SRC_IMM, 2'd3, 3'd2);
                8'h44: d = mk(MID_OP_ORL, MID_SRC_IMM, 2'd2, 3'd1);
                8'h45: d = mk(MID_OP_ORL, MID_SRC_DIR, 2'd2, 3'd1);
                8'h50: d = mk(MID_OP_JNC, MID_SRC_CARRY, 2'd2, 3'd2);
                8'h52: d = mk(MID_OP_ANL, MID_SRC_ACC, 2'd2, 3'd1);
                8'h53: d = mk(MID_OP_ANL, MID_SRC_IMM, 2'd3, 3'd2);
                8'h54: d = mk(MID_OP_ANL, MID_SRC_IMM, 2'd2, 3'd1);
                8'h55: d = mk(MID_OP_ANL, MID_SRC_DIR, 2'd2, 3'd1);
                8'h60: d = mk(MID_OP_JZ, MID_SRC_ACC, 2'd2, 3'd2);
                8'h62: d = mk(MID_OP_XRL, MID_SRC_ACC, 2'd2, 3'd1);
                8'h63: d = mk(MID_OP_XRL, MID_SRC_IMM, 2'd3, 3'd2);
                8'h64: d = mk(MID_OP_XRL, MID_SRC_IMM, 2'd2, 3'd1);
                8'h65: d = mk(MID_OP_XRL, MID_SRC_DIR, 2'd2, 3'd1);
                8'h70: d = mk(MID_OP_JNZ, MID_SRC_ACC, 2'd2, 3'd2);
                8'h72: d = mk(MID_OP_ORL_C, MID_SRC_DIR, 2'd2, 3'd2);
                8'h73: d = mk(MID_OP_JMP_IND, MID_SRC_ACC, 2'd1, 3'd2);
                8'h74: d = mk(MID_OP_MOV, MID_SRC_IMM, 2'd2, 3'd1);
                8'h75: d = mk(MID_OP_MOV, MID_SRC_IMM, 2'd3, 3'd2);
                8'h80: d = mk(MID_OP_SJMP, MID_SRC_NONE, 2'd2, 3'd2);
                8'h82: d = mk(MID_OP_ANL_C, MID_SRC_DIR, 2'd2, 3'd2);
                8'h83: d = mk(MID_OP_MOVC_PC, MID_SRC_ACC, 2'd1, 3'd2);
                8'h84: d = mk(MID_OP_DIV, MID_SRC_ACC, 2'd1,
                              `MID_MUL_CYC);
                8'h85: d = mk(MID_OP_MOV, MID_SRC_DIR, 2'd3, 3'd2);
                8'h90: d = mk(MID_OP_MOV_DP, MID_SRC_IMM, 2'd3, 3'd2);
                8'h92: d = mk(MID_OP_MOV_BC, MID_SRC_CARRY, 2'd2, 3'd2);
                8'h93: d = mk(MID_OP_MOVC_DP, MID_SRC_ACC, 2'd1, 3'd2);
                8'h94: d = mk(MID_OP_SUBB, MID_SRC_IMM, 2'd2, 3'd1);
                8'h95: d = mk(MID_OP_SUBB, MID_SRC_DIR, 2'd2, 3'd1);
                8'hA0: d = mk(MID_OP_ORL_NC, MID_SRC_DIR, 2'd2, 3'd2);
                8'hA2: d = mk(MID_OP_MOV_CB, MID_SRC_DIR, 2'd2, 3'd1);
                8'hA3: d = mk(MID_OP_INC_DP, MID_SRC_NONE, 2'd1, 3'd2);
                8'hA4: d = mk(MID_OP_MUL, MID_SRC_ACC, 2'd1,
                              `MID_MUL_CYC);
                8'hB0: d = mk(MID_OP_ANL_NC, MID_SRC_DIR, 2'd2, 3'd2);
                8'hB2: d = mk(MID_OP_CPL_BIT, MID_SRC_DIR, 2'd2, 3'd1);
                8'hB3: d = mk(MID_OP_CPL_BIT, MID_SRC_CARRY, 2'd1, 3'd1);
                8'hB4: d = mk(MID_OP_CJNE, MID_SRC_IMM, 2'd3, 3'd2);
                8'hB5: d = mk(MID_OP_CJNE, MID_SRC_DIR, 2'd3, 3'd2);
                8'hC0: d = mk(MID_OP_PUSH, MID_SRC_DIR, 2'd2, 3'd2);
                8'hC2: d = mk(MID_OP_CLR_BIT, MID_SRC_DIR, 2'd2, 3'd1);
                8'hC3: d = mk(MID_OP_CLR_BIT, MID_SRC_CARRY, 2'd1, 3'd1);
                8'hC4: d = mk(MID_OP_SWAP, MID_SRC_ACC, 2'd1, 3'd1);
                8'hC5: d = mk(MID_OP_XCH, MID_SRC_DIR, 2'd2, 3'd1);
                8'hD0: d = mk(MID_OP_POP, MID_SRC_DIR, 2'd2, 3'd2);
                8'hD2: d = mk(MID_OP_SET_BIT, MID_SRC_DIR, 2'd2, 3'd1);
                8'hD3: d = mk(MID_OP_SET_BIT, MID_SRC_CARRY, 2'd1, 3'd1);
                8'hD4: d = mk(MID_OP_DA, MID_SRC_ACC, 2'd1, 3'd1);
                8'hD5: d = mk(MID_OP_DJNZ, MID_SRC_DIR, 2'd3, 3'd2);
                8'hE0: d = mk(MID_OP_XRD, MID_SRC_NONE, 2'd1, 3'd2);
                8'hE2, 8'hE3: d = mk(MID_OP_XRD, MID_SRC_IND, 2'd1, 3'd2);
                8'hE4: d = mk(MID_OP_CLR_A, MID_SRC_ACC, 2'd1, 3'd1);
                8'hE5: d = mk(MID_OP_MOV, MID_SRC_DIR, 2'd2, 3'd1);
                8'hF0: d = mk(MID_OP_XWR, MID_SRC_ACC, 2'd1, 3'd2);
                8'hF2, 8'hF3: d = mk(MID_OP_XWR, MID_SRC_IND, 2'd1, 3'd2);
                8'hF4: d = mk(MID_OP_CPL_A, MID_SRC_ACC, 2'd1, 3'd1);
                8'hF5: d = mk(MID_OP_MOV, MID_SRC_ACC, 2'd2, 3'd1);
                `MID_OPC_TRAP_STORE: begin
                    // extension select picks the meaning
                    if (sel == `MID_EXT_SEL_STORE) begin
                        d = mk(MID_OP_STORE_PM, MID_SRC_ACC, 2'd1, 3'd2);
                    end else begin
                        d = mk(MID_OP_TRAP, MID_SRC_NONE, 2'd1, 3'd1);
                    end
                end
                default: d = mk(MID_OP_RSV, MID_SRC_NONE, 2'd1, 3'd1);
            endcase
            if (o[1:0] == 2'b11 && o[7:4] == 4'h0) begin
                d.src = MID_SRC_ACC;
            end
            d.wreg = {2'b00, o[0]};
            d.use_wreg = (o[3:1] == 3'b001) && o[7:5] >= 3'd7;
        end
        d.ext_access = (d.op == MID_OP_XRD || d.op == MID_OP_XWR);
        d.branch = d.op inside {MID_OP_ACALL, MID_OP_LCALL, MID_OP_RET,
            MID_OP_RETI, MID_OP_AJMP, MID_OP_LJMP, MID_OP_SJMP, MID_OP_JC,
            MID_OP_JNC, MID_OP_JB, MID_OP_JNB, MID_OP_JBC, MID_OP_JMP_IND,
            MID_OP_JZ, MID_OP_JNZ, MID_OP_CJNE, MID_OP_DJNZ};
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign fetch_ready = s_r.st != MID_ST_EXEC;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            MID_ST_IDLE: begin
                if (fetch_valid) begin
                    s_nxt.dec = decode(fetch_byte, extended_opcode_select);
                    s_nxt.bytes_left = s_nxt.dec.len - 2'd1;
                    s_nxt.mc_left = s_nxt.dec.cyc;
                    s_nxt.phase = 1'b0;
                    s_nxt.st = (s_nxt.dec.len == 2'd1) ? MID_ST_EXEC
                                                       : MID_ST_OPND;
                end
            end
            MID_ST_OPND: begin
                if (fetch_valid) begin
                    s_nxt.bytes_left = s_r.bytes_left - 2'd1;
                    if (s_r.bytes_left == 2'd1) begin
                        s_nxt.st = MID_ST_EXEC;
                    end
                end
            end
            MID_ST_EXEC: begin
                // two clocks per machine cycle
                s_nxt.phase = ~s_r.phase;
                if (s_r.phase) begin
                    s_nxt.mc_left = s_r.mc_left - 3'd1;
                    if (s_r.mc_left == 3'd1) begin
                        s_nxt.st = MID_ST_IDLE;
                        s_nxt.done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            s_r <= '{st: MID_ST_IDLE, dec: '0, bytes_left: 2'd0,
                     mc_left: 3'd0, phase: 1'b0, done: 1'b0};
            opnd1_r <= 8'h00;
            opnd2_r <= 8'h00;
        end else begin
            s_r <= s_nxt;
            if (s_r.st == MID_ST_OPND && fetch_valid) begin
                if (s_r.bytes_left == s_r.dec.len - 2'd1) begin
                    opnd1_r <= fetch_byte;
                end else begin
                    opnd2_r <= fetch_byte;
                end
            end
        end
    end

    assign dec_out = s_r.dec;
    assign opnd1 = opnd1_r;
    assign opnd2 = opnd2_r;
    assign busy = s_r.st != MID_ST_IDLE;
    assign mc_tick = s_r.st == MID_ST_EXEC && s_r.phase;
    assign insn_done = s_r.done;

    ////////////////////////////////////////////////////////////////////
    property p_exec_len;
        @(posedge clock) disable iff (!rst_s2_r)
        (s_r.st == MID_ST_IDLE && s_nxt.st == MID_ST_EXEC)
            |=> (s_r.st == MID_ST_EXEC) [*2];
    endproperty
    a_exec_len: assert property (p_exec_len)
        else $error("machine cycle shorter than two clocks");

    property p_muldiv;
        @(posedge clock) disable iff (!rst_s2_r)
        (s_r.st == MID_ST_IDLE && fetch_valid &&
         (fetch_byte == 8'hA4 || fetch_byte == 8'h84))
            |=> ##8 insn_done;
    endproperty
    a_muldiv: assert property (p_muldiv)
        else $error("multiply or divide not four machine cycles");

    property p_wreg;
        @(posedge clock) disable iff (!rst_s2_r)
        (s_r.st == MID_ST_IDLE && fetch_valid && fetch_byte[3])
            |=> dec_out.wreg == $past(fetch_byte[2:0]);
    endproperty
    a_wreg: assert property (p_wreg)
        else $error("register number not from low opcode bits");

    property p_page;
        @(posedge clock) disable iff (!rst_s2_r)
        (s_r.st == MID_ST_IDLE && fetch_valid && fetch_byte[3:0] == 4'h1)
            |=> dec_out.page == $past(fetch_byte[7:5]);
    endproperty
    a_page: assert property (p_page)
        else $error("absolute target page not from top opcode bits");

    property p_ext_select;
        @(posedge clock) disable iff (!rst_s2_r)
        (s_r.st == MID_ST_IDLE && fetch_valid &&
         fetch_byte == `MID_OPC_TRAP_STORE)
            |=> dec_out.op == (($past(extended_opcode_select) ==
                                `MID_EXT_SEL_STORE) ? MID_OP_STORE_PM
                                                    : MID_OP_TRAP);
    endproperty
    a_ext_select: assert property (p_ext_select)
        else $error("extension select not applied to store or break");

    property p_done_pulse;
        @(posedge clock) disable iff (!rst_s2_r)
        insn_done |=> !insn_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("completion pulse longer than one clock");

    property p_tick_pair;
        @(posedge clock) disable iff (!rst_s2_r)
        mc_tick |=> !mc_tick;
    endproperty
    a_tick_pair: assert property (p_tick_pair)
        else $error("machine cycle tick on adjacent clocks");
endmodule

// >>> common/mid_map.svh
// offsets, field positions and timing counts of the opcode decoder
// assumes: included by the package user, no surroundings needed
`ifndef MID_MAP_SVH
`define MID_MAP_SVH
`define MID_CLK_PER_MC 2
`define MID_REG_LSB 0
`define MID_REG_W 3
`define MID_AJ_LOW_W 5
`define MID_AJ_JMP_LOW 5'h01
`define MID_AJ_CALL_LOW 5'h11
`define MID_EXT_SEL_STORE 4'h0
`define MID_OPC_TRAP_STORE 8'hA5
`define MID_MUL_CYC 3'h4
`endif

// >>> common/mid_pkg.sv
// types of the opcode decoder
// assumes: nothing beyond the map header
package mid_pkg;
    typedef enum logic [5:0] {
        MID_OP_NOP = 6'd0, MID_OP_ADD, MID_OP_ADDC, MID_OP_SUBB, MID_OP_INC,
        MID_OP_DEC, MID_OP_INC_DP, MID_OP_MUL, MID_OP_DIV, MID_OP_DA,
        MID_OP_ANL, MID_OP_ORL, MID_OP_XRL, MID_OP_CLR_A, MID_OP_CPL_A,
        MID_OP_SWAP, MID_OP_RL, MID_OP_RLC, MID_OP_RR, MID_OP_RRC,
        MID_OP_MOV, MID_OP_MOV_DP, MID_OP_MOVC_DP, MID_OP_MOVC_PC,
        MID_OP_XRD, MID_OP_XWR, MID_OP_PUSH, MID_OP_POP, MID_OP_XCH,
        MID_OP_XCHD, MID_OP_CLR_BIT, MID_OP_SET_BIT, MID_OP_CPL_BIT,
        MID_OP_ANL_C, MID_OP_ANL_NC, MID_OP_ORL_C, MID_OP_ORL_NC,
        MID_OP_MOV_CB, MID_OP_MOV_BC, MID_OP_ACALL, MID_OP_LCALL,
        MID_OP_RET, MID_OP_RETI, MID_OP_AJMP, MID_OP_LJMP, MID_OP_SJMP,
        MID_OP_JC, MID_OP_JNC, MID_OP_JB, MID_OP_JNB, MID_OP_JBC,
        MID_OP_JMP_IND, MID_OP_JZ, MID_OP_JNZ, MID_OP_CJNE, MID_OP_DJNZ,
        MID_OP_STORE_PM, MID_OP_TRAP, MID_OP_RSV
    } mid_op_t;
    typedef enum logic [2:0] {
        MID_SRC_NONE = 3'd0, MID_SRC_REG, MID_SRC_DIR, MID_SRC_IND,
        MID_SRC_IMM, MID_SRC_ACC, MID_SRC_CARRY
    } mid_src_t;
    typedef enum logic [2:0] {
        MID_ST_IDLE = 3'b001,
        MID_ST_OPND = 3'b010,
        MID_ST_EXEC = 3'b100
    } mid_st_t;
    typedef struct packed {
        mid_op_t op;
        mid_src_t src;
        logic [1:0] len;
        logic [2:0] cyc;
        logic [2:0] wreg;
        logic use_wreg;
        logic [2:0] page;
        logic ext_access;
        logic branch;
    } mid_dec_t;
    typedef struct packed {
        mid_st_t st;
        mid_dec_t dec;
        logic [1:0] bytes_left;
        logic [2:0] mc_left;
        logic phase;
        logic done;
    } mid_state_t;
endpackage

// >>> test/mid_fetch_model.sv
// far side model: program memory fetch stream, one instruction per go
// assumes: fetch_ready is settled between clock edges
`timescale 1ns/1ns
module mid_fetch_model (
    // clock
    input wire logic clock,
    // request from the bench
    input wire logic go,
    input wire logic [23:0] words,
    input wire logic [1:0] count,
    input wire logic slow,
    // fetch stream
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [7:0] fetch_byte,
    // edge number at which the last byte was taken
    output logic [31:0] last_take
);
    logic [31:0] edges = 32'h0000_0000;
    logic ok;
    initial begin
        fetch_valid = 1'b0;
        fetch_byte = 8'h5a;
        last_take = 32'h0000_0000;
    end
    always @(posedge clock) begin
        edges <= edges + 1;
    end
    always begin
        @(posedge clock);
        if (go) begin
            // opcode first, then its operand bytes
            for (int i = 0; i < int'(count); i++) begin
                if (slow) begin
                    #1;
                    fetch_valid = 1'b0;
                    fetch_byte = ~fetch_byte;
                    @(posedge clock);
                end
                #1;
                fetch_valid = 1'b1;
                fetch_byte = words[23 - 8 * i -: 8];
                ok = 1'b0;
                while (!ok) begin
                    @(negedge clock);
                    ok = fetch_ready;
                    @(posedge clock);
                end
            end
            last_take = edges + 1;
            #1;
            fetch_valid = 1'b0;
            // released bus shows no stale value
            fetch_byte = ~fetch_byte;
        end
    end
endmodule

// >>> test/test_mid_decoder.sv
// self-checking bench of the opcode decoder against the fetch model
// assumes: mid_pkg and the fetch model are compiled first
`timescale 1ns/1ns
module test_mid_decoder import mid_pkg::*; ();
    logic clock, nrst, go, slow, fetch_valid, fetch_ready;
    logic busy, mc_tick, insn_done;
    logic [3:0] sel;
    logic [7:0] fetch_byte, opnd1, opnd2, o;
    logic [15:0] e;
    logic [23:0] words;
    logic [1:0] count;
    logic [31:0] last_take;
    logic [31:0] cnt = 32'h0000_0000;
    mid_dec_t dec_out;
    int miscompares, checked, seed, ticks;
    // entry: opcode, length, time; bit 3 marks an eight-register block
    logic [15:0] tbl [$] = '{
        16'h2819, 16'h2521, 16'h2421, 16'h3819, 16'h3521, 16'h3421,
        16'h9819, 16'h9521, 16'h9421, 16'h5819, 16'h5521, 16'h5332,
        16'h4819, 16'h4332, 16'h6819, 16'h6332, 16'hE411, 16'hF411,
        16'hC411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hE819,
        16'hF819, 16'hA82A, 16'h9032, 16'h9312, 16'h8312, 16'hE012,
        16'hF012, 16'hE212, 16'hF212, 16'hC022, 16'hD022, 16'hC819,
        16'hC521, 16'hC611, 16'hD611, 16'h8222, 16'hB022, 16'h7222,
        16'hA022, 16'hA221, 16'h9222, 16'hC311, 16'hD311, 16'hB311,
        16'hC221, 16'h1232, 16'h2212, 16'h3212, 16'h0232, 16'h8022,
        16'h7312, 16'h4022, 16'h5022, 16'h6022, 16'h7022, 16'h2032,
        16'h3032, 16'h1032, 16'hB532, 16'hB432, 16'hB83A, 16'hB632,
        16'hD83A, 16'hD532, 16'hA414, 16'h8414, 16'h0122, 16'h1122,
        16'h0011, 16'hA512};
    mid_decoder i_mid_decoder (
        .clock(clock), .nrst(nrst), .extended_opcode_select(sel),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_ready(fetch_ready), .dec_out(dec_out), .opnd1(opnd1),
        .opnd2(opnd2), .busy(busy), .mc_tick(mc_tick),
        .insn_done(insn_done));
    mid_fetch_model i_mid_fetch_model (
        .clock(clock), .go(go), .words(words), .count(count), .slow(slow),
        .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .last_take(last_take));
    ////////////////////////////////////////////////////////////////////
    function automatic mid_op_t exp_op(logic [7:0] op, logic [3:0] s);
        case (op)
            8'h00: exp_op = MID_OP_NOP;
            8'hA4: exp_op = MID_OP_MUL;
            8'h84: exp_op = MID_OP_DIV;
            8'hA5: exp_op = (s == 4'h0) ? MID_OP_STORE_PM : MID_OP_TRAP;
            default: exp_op = MID_OP_RSV;
        endcase
    endfunction
    task automatic check(logic ok, string what);
        checked++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic run(logic [15:0] ent, logic [7:0] op, logic s,
                       logic [3:0] sl);
        logic [7:0] b1, b2;
        logic [2:0] c;
        int n;
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        c = (op == 8'hA5 && sl != 4'h0) ? 3'h1 : ent[2:0];
        ticks = 0;
        n = 0;
        @(posedge clock);
        #1;
        words = {op, b1, b2};
        count = ent[5:4];
        slow = s;
        sel = sl;
        go = 1'b1;
        @(posedge clock);
        #1;
        go = 1'b0;
        do begin
            @(negedge clock);
            ticks += int'(mc_tick === 1'b1);
            n++;
        end while (insn_done !== 1'b1 && n < 80);
        check(n < 80, "no completion");
        check(busy === 1'b0, "still busy after completion");
        check(cnt - last_take === 32'(2 * c), "run length");
        check(ticks === int'(c), "machine cycle count");
        check(dec_out.len === ent[5:4] && dec_out.cyc === c, "size");
        if (ent[3]) check(dec_out.wreg === op[2:0], "register");
        if (op[3:0] == 4'h1) check(dec_out.page === op[7:5], "page");
        if (exp_op(op, sl) != MID_OP_RSV) check(dec_out.op === exp_op(op, sl), "op");
        if ((op & 8'hEC) == 8'hE0 && op[1:0] != 2'b01) check(dec_out.ext_access === 1'b1, "ext");
        if (ent[5:4] > 2'd1) check(opnd1 === b1, "first operand");
        if (ent[5:4] == 2'd3) check(opnd2 === b2, "second operand");
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cnt <= cnt + 1;
    end
    initial begin
        #(20000 * 40);
        miscompares++;
        report_and_stop();
    end
    initial begin
        seed = 56;
        nrst = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        sel = 4'h0;
        words = 24'h0000_00;
        count = 2'd1;
        repeat (16) @(posedge clock);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clock);
        // every table entry, fast with store select, slow with break
        for (int p = 0; p < 2; p++) begin
            foreach (tbl[i]) run(tbl[i], tbl[i][15:8], p[0], p[0] ? 4'h9 : 4'h0);
        end
        repeat (150) begin
            e = tbl[$unsigned($random(seed)) % tbl.size()];
            o = e[15:8];
            if (e[3]) o[2:0] = 3'($random(seed));
            if (o[3:0] == 4'h1) o[7:5] = 3'($random(seed));
            run(e, o, 1'($random(seed)), 4'($random(seed)));
        end
        report_and_stop();
    end
endmodule
